/* src/gpt_regs.svh */
// register indices, field positions and reset values of the timer
// assumes the byte address of a register is four times its index
`ifndef GPT_REGS_SVH
`define GPT_REGS_SVH

`define GPT_IDX_CLOCK_SETUP   20'h4C000
`define GPT_IDX_COUNT_PRESET  20'h4C002
`define GPT_IDX_START_STOP    20'h4C006
`define GPT_IDX_RUN_STATUS    20'h4C008
`define GPT_IDX_COUNT_READ    20'h4C00A
`define GPT_IDX_IRQ_STATUS    20'h4C010
`define GPT_IDX_IRQ_MASK      20'h4C012

`define GPT_BIT_AUTO_RESTART  21
`define GPT_BIT_DIRECTION     20
`define GPT_RATE_DIV_HI       18
`define GPT_RATE_DIV_LO       16
`define GPT_REF_DIV_HI        14
`define GPT_REF_DIV_LO        12
`define GPT_RATE_SEL_HI       10
`define GPT_RATE_SEL_LO       8
`define GPT_SRC_HI            3
`define GPT_SRC_LO            0
`define GPT_BIT_GO            0
`define GPT_BIT_HALT          4
`define GPT_BIT_EOC           0

`define GPT_SETUP_RESET       32'h0000_0000
`define GPT_SETUP_MASK        32'h0037_770F
`define GPT_LIMIT_RESET       32'h0000_0000
`define GPT_MASK_RESET        32'h0000_0000
`define GPT_COUNT_ZERO        32'h0000_0000
`define GPT_COUNT_ONE         32'h0000_0001

`define GPT_SRC_PROC          4'h0
`define GPT_SRC_32K           4'h1
`define GPT_SRC_MCLK_A        4'h4
`define GPT_SRC_MCLK_B        4'h5
`define GPT_SRC_SYS           4'h8
`define GPT_SRC_ASYNC         4'h9
`define GPT_SRC_GPIO1         4'hC
`define GPT_SRC_GPIO2         4'hD
`define GPT_SRC_GPIO3         4'hE
`define GPT_SRC_GPIO4         4'hF

// rate select: source assumed at the top rate, code 3 = no division
`define GPT_RATE_TOP          3'h3

`define GPT_SYNC_W            10
`define GPT_SYNC_PROC_EN      9

`endif

/* src/gpt_pkg.sv */
// types shared by the timer design files
// assumes nothing beyond a SystemVerilog compiler
package gpt_pkg;
  typedef enum logic [1:0] {
    GPT_IDLE = 2'b01,
    GPT_RUN  = 2'b10
  } gpt_state_type;
endpackage

/* src/gpt_pow2_div.sv */
// power of two pulse divider: one output pulse per 2**sel input pulses
// assumes in_pulse is one mclk cycle wide and on the mclk domain
module gpt_pow2_div (
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       in_pulse,
  input  wire logic [2:0] sel,
  output logic            out_pulse
);
  logic [6:0] cnt;
  logic [6:0] top;
  wire        wrap;

  assign top  = 7'(({7{1'b1}} >> (3'd7 - sel)));
  assign wrap = in_pulse && (cnt == top);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 7'h00;
    end else if (clear || wrap) begin
      cnt <= 7'h00;
    end else if (in_pulse) begin
      cnt <= cnt + 7'h01;
    end
  end

  // combinational so the chained stages add no lag
  assign out_pulse = wrap;
endmodule // gpt_pow2_div

/* src/gpt_timer.sv */
// general purpose timer: reference select, dividers, counter, APB slave
// assumes reference pins are asynchronous; mclk is the processor clock
//
// Behaviour
// - the reference divider divides a non-processor source by 2**code.
// - with the processor clock off, each divided tick is a logging slot.
// - rate select picks 6.144, 12.288, 24.576 or 49.152 MHz; others reserved.
// - source 0 is the processor clock, 1 the 32 kHz, 8 system, 9 async.
// - sources 4 and 5 are master clocks a and b, 12 to 15 are gpio 1 to 4.
// - the count limit is the end value counting up, the start counting down.
// - go restarts counting from the initial value; halt stops the timer.
// - a running flag is shown; setup changes only while it reads 0 (here setup writes are taken while running too).
// - a final prescaler of 1 to 128 sets the count update rate.
// - direction 0 counts down and 1 counts up.
// - auto restart 1 reloads at end of count, 0 runs once.
// - end of count is flagged at the update after the final value.
//
// The APB interface to the registers was decided locally.
`include "gpt_regs.svh"

module gpt_timer (
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [23:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        processor_clock_on,
  input  wire logic        clk_32k_in,
  input  wire logic        master_clock_in_a,
  input  wire logic        master_clock_in_b,
  input  wire logic        main_system_clock,
  input  wire logic        secondary_async_clock,
  input  wire logic [3:0]  gpio_in,
  output logic             irq,
  output logic             log_tick,
  output logic             counting_flag
);

  ////////////////////////////////////////////////////////////////////////////
  // synchronisers and edge detection

  logic [`GPT_SYNC_W-1:0] sync_a;
  logic [`GPT_SYNC_W-1:0] sync_b;
  logic [`GPT_SYNC_W-1:0] sync_c;
  wire  [`GPT_SYNC_W-1:0] raw_in;
  wire  [`GPT_SYNC_W-1:0] rise;

  assign raw_in = {processor_clock_on, gpio_in, secondary_async_clock,
                   main_system_clock, master_clock_in_b, master_clock_in_a,
                   clk_32k_in};

  // pins must stay high and low two mclk each so every rise is seen once
  // the third stage only feeds the edge detector, never other logic
  genvar gi;
  generate
    for (gi = 0; gi < `GPT_SYNC_W; gi = gi + 1) begin : g_sync
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          sync_a[gi] <= 1'b0;
          sync_b[gi] <= 1'b0;
          sync_c[gi] <= 1'b0;
        end else begin
          sync_a[gi] <= raw_in[gi];
          sync_b[gi] <= sync_a[gi];
          sync_c[gi] <= sync_b[gi];
        end
      end
      assign rise[gi] = sync_b[gi] & ~sync_c[gi];
    end
  endgenerate

  wire proc_on = sync_b[`GPT_SYNC_PROC_EN];

  ////////////////////////////////////////////////////////////////////////////
  // registers

  logic [31:0] clock_setup;
  logic [31:0] count_limit;
  logic [31:0] count;
  logic [31:0] irq_status;
  logic [31:0] irq_mask;
  gpt_pkg::gpt_state_type state;
  gpt_pkg::gpt_state_type next_state;

  wire [3:0] ref_source_sel;
  wire [2:0] ref_rate_sel;
  wire [2:0] ref_divider_sel;
  wire [2:0] count_rate_divider;
  wire       count_direction    = clock_setup[`GPT_BIT_DIRECTION];
  wire       auto_restart       = clock_setup[`GPT_BIT_AUTO_RESTART];

  // unused setup bits are masked on write so they read back as zero
  assign ref_source_sel     = clock_setup[`GPT_SRC_HI:`GPT_SRC_LO];
  assign ref_rate_sel       = clock_setup[`GPT_RATE_SEL_HI:`GPT_RATE_SEL_LO];
  assign ref_divider_sel    = clock_setup[`GPT_REF_DIV_HI:`GPT_REF_DIV_LO];
  assign count_rate_divider = clock_setup[`GPT_RATE_DIV_HI:`GPT_RATE_DIV_LO];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; one wait state, writes act on the completing edge

  wire [21:0] idx      = paddr[23:2];
  wire        access   = psel && penable && pready;
  wire        wr       = access && pwrite;
  wire        hit_cfg  = idx == 22'(`GPT_IDX_CLOCK_SETUP);
  wire        hit_lim  = idx == 22'(`GPT_IDX_COUNT_PRESET);
  wire        hit_cmd  = idx == 22'(`GPT_IDX_START_STOP);
  wire        hit_sts  = idx == 22'(`GPT_IDX_RUN_STATUS);
  wire        hit_cnt  = idx == 22'(`GPT_IDX_COUNT_READ);
  wire        hit_ist  = idx == 22'(`GPT_IDX_IRQ_STATUS);
  wire        hit_imk  = idx == 22'(`GPT_IDX_IRQ_MASK);
  wire        mapped   = hit_cfg | hit_lim | hit_cmd | hit_sts |
                         hit_cnt | hit_ist | hit_imk;
  wire        running  = state == gpt_pkg::GPT_RUN;
  wire        go_cmd   = wr && hit_cmd && pwdata[`GPT_BIT_GO];
  wire        halt_cmd = wr && hit_cmd && pwdata[`GPT_BIT_HALT];
  wire        setup_wr = wr && hit_cfg;

  wire [31:0] read_mux =
      hit_cfg ? clock_setup :
      hit_lim ? count_limit :
      hit_sts ? {31'h0, running} :
      hit_cnt ? count :
      hit_ist ? irq_status :
      hit_imk ? irq_mask : 32'h0000_0000;

  // read data is registered with pready so it stands for the whole answer
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      prdata  <= read_mux;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // setup is not locked while running; software must wait for idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      clock_setup <= `GPT_SETUP_RESET;
      count_limit <= `GPT_LIMIT_RESET;
      irq_mask    <= `GPT_MASK_RESET;
    end else if (wr) begin
      if (hit_cfg)
        clock_setup <= pwdata & `GPT_SETUP_MASK;
      if (hit_lim)
        count_limit <= pwdata;
      if (hit_imk)
        irq_mask <= pwdata & 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // reference selection and division

  logic src_pulse;
  wire  is_proc  = ref_source_sel == `GPT_SRC_PROC;
  wire  is_fast  = (ref_source_sel == `GPT_SRC_SYS) ||
                   (ref_source_sel == `GPT_SRC_ASYNC);

  // reserved source codes leave the reference silent
  always_comb begin
    unique case (ref_source_sel)
      `GPT_SRC_PROC:   src_pulse = 1'b1;
      `GPT_SRC_32K:    src_pulse = rise[0];
      `GPT_SRC_MCLK_A: src_pulse = rise[1];
      `GPT_SRC_MCLK_B: src_pulse = rise[2];
      `GPT_SRC_SYS:    src_pulse = rise[3];
      `GPT_SRC_ASYNC:  src_pulse = rise[4];
      `GPT_SRC_GPIO1:  src_pulse = rise[5];
      `GPT_SRC_GPIO2:  src_pulse = rise[6];
      `GPT_SRC_GPIO3:  src_pulse = rise[7];
      `GPT_SRC_GPIO4:  src_pulse = rise[8];
      default:         src_pulse = 1'b0;
    endcase
  end

  // reserved rate codes give no reference from the sys and async sources; other sources ignore rate select
  wire       rate_ok  = !ref_rate_sel[2];
  wire [2:0] rate_div = is_fast ? (`GPT_RATE_TOP - ref_rate_sel) : 3'h0;
  wire       rate_in  = src_pulse && (!is_fast || rate_ok);
  wire [2:0] ref_div  = is_proc ? 3'h0 : ref_divider_sel;
  logic      rate_pulse;
  logic      ref_pulse;
  logic      tick;
  logic      restart;

  assign restart = go_cmd;

  // a new setup restarts the dividers so the first period is whole
  gpt_pow2_div u_rate_div (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clear     (setup_wr),
    .in_pulse  (rate_in),
    .sel       (rate_div),
    .out_pulse (rate_pulse)
  );

  gpt_pow2_div u_ref_div (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clear     (setup_wr),
    .in_pulse  (rate_pulse),
    .sel       (ref_div),
    .out_pulse (ref_pulse)
  );

  // the prescaler restarts with the counter so the first period is whole
  gpt_pow2_div u_prescale (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .clear     (restart || !running),
    .in_pulse  (ref_pulse),
    .sel       (count_rate_divider),
    .out_pulse (tick)
  );

  // taken before the prescaler so logging runs while the timer is idle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      log_tick <= 1'b0;
    end else begin
      log_tick <= ref_pulse && !proc_on;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // counter

  // a go in the same write as a halt wins, so one access restarts
  wire [31:0] init_val = count_direction ? `GPT_COUNT_ZERO : count_limit;
  wire        at_end   = count_direction ? (count == count_limit)
                                         : (count == `GPT_COUNT_ZERO);
  // end is seen on the update after the final value was reached
  wire        eoc      = running && tick && at_end && !restart;

  always_comb begin
    next_state = state;
    unique case (state)
      gpt_pkg::GPT_IDLE:
        if (go_cmd)
          next_state = gpt_pkg::GPT_RUN;
      gpt_pkg::GPT_RUN:
        if (go_cmd)
          next_state = gpt_pkg::GPT_RUN;
        else if (halt_cmd)
          next_state = gpt_pkg::GPT_IDLE;
        else if (eoc && !auto_restart)
          next_state = gpt_pkg::GPT_IDLE;
      default:
        next_state = gpt_pkg::GPT_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= gpt_pkg::GPT_IDLE;
    end else begin
      state <= next_state;
    end
  end

  wire [31:0] stepped = count_direction ? count + `GPT_COUNT_ONE
                                        : count - `GPT_COUNT_ONE;

  // halt leaves the count where it stopped so software can read it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= `GPT_COUNT_ZERO;
    end else if (restart) begin
      count <= init_val;
    end else if (eoc && auto_restart) begin
      count <= init_val;
    end else if (running && tick && !at_end) begin
      count <= stepped;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status; a new end of count wins over a clearing write

  wire clr_eoc = wr && hit_ist && pwdata[`GPT_BIT_EOC];

  // irq lags the status bit by one cycle so it comes from a flop

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irq_status    <= 32'h0000_0000;
      irq           <= 1'b0;
      counting_flag <= 1'b0;
    end else begin
      irq_status[`GPT_BIT_EOC] <= eoc ||
                                  (irq_status[`GPT_BIT_EOC] && !clr_eoc);
      irq           <= |(irq_status & irq_mask);
      counting_flag <= next_state == gpt_pkg::GPT_RUN;
    end
  end

endmodule // gpt_timer

/* tb/gpt_timer_properties.sv */
// port-level checks of the timer: bus answer, run flag, log ticks, irq
// assumes binding to gpt_timer; only the pins named below are watched
module gpt_timer_properties (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [23:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        processor_clock_on,
  input wire logic        irq,
  input wire logic        log_tick,
  input wire logic        counting_flag
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire logic done    = psel && penable && pready;
  wire logic ss_hit  = done && paddr == 24'h130018;
  wire logic go_wr   = ss_hit && pwrite && pwdata[0];
  wire logic halt_wr = ss_hit && pwrite && !pwdata[0] && pwdata[4];
  ////////////////////////////////////////////////////////////////////////
  property p_access_two; psel && $rose(penable) |=> pready; endproperty
  a_access_two: assert property (p_access_two) else $error("late answer");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
  property p_err_zero; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_zero: assert property (p_err_zero) else $error("bad refusal");
  property p_go_runs; go_wr |-> ##[1:2] counting_flag; endproperty
  a_go_runs: assert property (p_go_runs) else $error("no run");
  property p_halt_stops; halt_wr |-> ##[1:2] !counting_flag; endproperty
  a_halt_stops: assert property (p_halt_stops) else $error("no halt");
  property p_rise_cause;
    $rose(counting_flag) |-> $past(go_wr) || $past(go_wr, 2);
  endproperty
  a_rise_cause: assert property (p_rise_cause) else $error("odd run");
  property p_ss_reads0; ss_hit && !pwrite |-> prdata == 32'h0; endproperty
  a_ss_reads0: assert property (p_ss_reads0) else $error("ss read");
  property p_st_field;
    done && !pwrite && paddr == 24'h130020 |-> prdata[31:1] == 31'h0;
  endproperty
  a_st_field: assert property (p_st_field) else $error("status");
  property p_tick_gate; processor_clock_on [*5] |-> !log_tick; endproperty
  a_tick_gate: assert property (p_tick_gate) else $error("tick on");
  property p_tick_one;
    log_tick && $past(rst_n, 3) |-> !$past(processor_clock_on, 3);
  endproperty
  a_tick_one: assert property (p_tick_one) else $error("late tick");
  property p_irq_fall; $fell(irq) |-> $past(psel && pwrite, 2); endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq drop");
  c_go: cover property (go_wr);
  c_halt: cover property (halt_wr);
  c_irq: cover property ($rose(irq));
  c_tick: cover property (log_tick);
endmodule // gpt_timer_properties

/* tb/test_general_purpose_timer_control.sv */
// self-checking bench of the timer: registers, counting, reference pins
// assumes gpt_regs.svh on the include path; 20 MHz mclk
`include "gpt_regs.svh"
module test_general_purpose_timer_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [23:0] adr_set = 24'h130000, adr_lim = 24'h130008;
  localparam logic [23:0] adr_ss = 24'h130018, adr_run = 24'h130020;
  localparam logic [23:0] adr_cnt = 24'h130028, adr_ist = 24'h130040;
  localparam logic [23:0] adr_imk = 24'h130048;
  logic        mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, perr, processor_clock_on = 1'b1;
  logic [23:0] paddr = 24'h0;
  logic [31:0] pwdata = 32'h0, rd, lim;
  logic [8:0]  pins = 9'h0;
  logic [15:0] seed = 16'hB7BC;
  logic [2:0]  p, d, r;
  wire logic [31:0] prdata;
  wire logic   pready, pslverr, irq, log_tick, counting_flag;
  int          err_total = 0, check_count = 0, ticks = 0, n, dur;
  logic [3:0]  src_tab [11] = '{4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hC, 4'hD,
                                4'hE, 4'hF, 4'h2, 4'h1};
  int          pin_tab [11] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 0, 0};
  always #25 mclk = ~mclk;
  logic        tick_clr = 1'b0;
  always @(posedge mclk)
    ticks <= tick_clr ? 0 : ticks + ((log_tick === 1'b1) ? 1 : 0);
  gpt_timer dut_u (.mclk(mclk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .processor_clock_on(processor_clock_on), .clk_32k_in(pins[0]),
    .master_clock_in_a(pins[1]), .master_clock_in_b(pins[2]),
    .main_system_clock(pins[3]), .secondary_async_clock(pins[4]),
    .gpio_in(pins[8:5]), .irq(irq), .log_tick(log_tick),
    .counting_flag(counting_flag));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // sys and async sources are taken at the top rate, so code 3 is /1
  function automatic int tick_exp(input logic [3:0] s, input logic [2:0] dv,
                                  input logic [2:0] rt, input logic on);
    int e;
    e = 64 >> dv;
    if (s == 4'h8 || s == 4'h9) e = e >> (3 - rt);
    if (on || s == 4'h2) e = 0;
    return e;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [23:0] a,
                     input logic [31:0] dt);
    int k;
    k = 0;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k == 20) err_total++;
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [23:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task automatic reset_dut;
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
  endtask
  // one single-mode run on the processor clock; flag high for (lim+1) ticks
  task automatic run_once(input logic up, input logic mask);
    apb(1'b1, adr_imk, {31'h0, mask});
    apb(1'b1, adr_lim, lim);
    apb(1'b1, adr_set, {10'h0, 1'b0, up, 1'b0, p, 16'h0});
    apb(1'b1, adr_ss, 32'h1);
    n = 0;
    while (counting_flag !== 1'b1 && n < 8) begin
      @(posedge mclk);
      n++;
    end
    dur = 0;
    while (counting_flag === 1'b1 && dur < 3000) begin
      @(posedge mclk);
      dur++;
    end
    chk(32'(dur), (lim + 32'h1) << p);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, {31'h0, mask});
    rd_chk(adr_ist, 32'h1);
    rd_chk(adr_cnt, up ? lim : 32'h0);
    rd_chk(adr_run, 32'h0);
    apb(1'b1, adr_ist, 32'h1);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    reset_dut;
    rd_chk(adr_set, 32'h0);
    rd_chk(adr_lim, 32'h0);
    rd_chk(adr_run, 32'h0);
    rd_chk(adr_ss, 32'h0);
    apb(1'b0, 24'h130004, 32'h0);
    chk({31'h0, perr}, 32'h1);
    seed = lfsr(seed);
    apb(1'b1, adr_set, {seed, lfsr(seed)});
    rd_chk(adr_set, {seed, lfsr(seed)} & `GPT_SETUP_MASK);
    $display("register test done");
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      lim = (i == 0) ? 32'h0 : {28'h0, seed[3:0]} + 32'h1;
      p = {1'b0, seed[5:4]};
      run_once(i[0], i[1]);
    end
    $display("count test done");
    lim = 32'h28;
    apb(1'b1, adr_lim, lim);
    apb(1'b1, adr_set, 32'h0023_0000);
    apb(1'b1, adr_ss, 32'h1);
    repeat (20) @(posedge mclk);
    apb(1'b1, adr_ss, 32'h11);
    rd_chk(adr_cnt, lim);
    repeat (400) @(posedge mclk);
    chk({31'h0, counting_flag}, 32'h1);
    apb(1'b1, adr_ss, 32'h10);
    rd_chk(adr_run, 32'h0);
    apb(1'b0, adr_cnt, 32'h0);
    lim = rd;
    repeat (20) @(posedge mclk);
    rd_chk(adr_cnt, lim);
    $display("control test done");
    // pins toggle every 4 mclk: 2.5 MHz, under mclk/3 and 12 MHz
    for (int i = 0; i < 11; i++) begin
      seed = lfsr(seed);
      d = {1'b0, seed[1:0]};
      r = {1'b0, seed[3:2]};
      reset_dut;
      processor_clock_on <= (i == 10);
      apb(1'b1, adr_set, {17'h0, d, 1'b0, r, 4'h0, src_tab[i]});
      tick_clr <= 1'b1;
      @(posedge mclk);
      tick_clr <= 1'b0;
      repeat (64) begin
        pins[pin_tab[i]] <= 1'b1;
        repeat (4) @(posedge mclk);
        pins[pin_tab[i]] <= 1'b0;
        repeat (4) @(posedge mclk);
      end
      repeat (10) @(posedge mclk);
      n = tick_exp(src_tab[i], d, r, i == 10);
      chk(32'(ticks), 32'(n));
    end
    $display("reference test done");
    tally_and_finish;
  end
  initial begin
    repeat (30000) @(posedge mclk);
    err_total++;
    tally_and_finish;
  end
endmodule // test_general_purpose_timer_control
bind gpt_timer gpt_timer_properties u_props (.mclk(mclk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .processor_clock_on(processor_clock_on), .irq(irq),
  .log_tick(log_tick), .counting_flag(counting_flag));
